// *** logic/hbs_pkg.sv ***
// Package with constants and types of the holding brake sequencer
//
// Overview of operation
// - Enabling power stage releases brake automatically
// - Operation Enabled waits for full release delay
// - Disabling power stage applies brake automatically
// - Current stays on during nameplate apply delay
// - Current cut only after total apply delay
// - Extra release delay: signed ms, 0..400
// - Extra apply delay: signed ms, 0..1000
// - Delay writes rejected while power stage enabled
// - New delay values used at next enable
// - Manual release only in states 3, 4, 9
// - Manual apply only at motor standstill
// - Enabling keeps manually applied brake applied
// - Manual apply overrides every release source
// - Jog cancel applies brake, disables power stage
// - Manual codes 0/1/2; 0 needed before 1
package hbs_pkg;

    localparam int unsigned HBS_CLK_PERIOD_NS = 20;
    localparam int unsigned HBS_MS_NS = 1000000;
    localparam int unsigned HBS_CYC_PER_MS = HBS_MS_NS / HBS_CLK_PERIOD_NS;

    localparam logic [15:0] HBS_OFS_EXTRA_RELEASE = 16'h050e;
    localparam logic [15:0] HBS_OFS_EXTRA_APPLY = 16'h0510;
    localparam logic [15:0] HBS_OFS_MANUAL_CTL = 16'h0814;

    localparam logic [15:0] HBS_RST_EXTRA_RELEASE = 16'h0000;
    localparam logic [15:0] HBS_RST_EXTRA_APPLY = 16'h0000;
    localparam logic [1:0] HBS_RST_MANUAL_CTL = 2'h0;

    localparam logic signed [15:0] HBS_EXTRA_MIN = 16'sh0000;
    localparam logic signed [15:0] HBS_EXTRA_RELEASE_MAX = 16'sh0190;
    localparam logic signed [15:0] HBS_EXTRA_APPLY_MAX = 16'sh03e8;

    localparam logic [1:0] HBS_MAN_AUTO = 2'h0;
    localparam logic [1:0] HBS_MAN_RELEASE = 2'h1;
    localparam logic [1:0] HBS_MAN_APPLY = 2'h2;

    localparam logic [3:0] HBS_OPST_SWITCH_ON_DISABLED = 4'h3;
    localparam logic [3:0] HBS_OPST_READY_TO_SWITCH_ON = 4'h4;
    localparam logic [3:0] HBS_OPST_FAULT = 4'h9;

    typedef enum logic [1:0] {
        HBS_OFF,
        HBS_RELEASING,
        HBS_ENABLED,
        HBS_APPLYING
    } hbs_state_t;

endpackage

// *** logic/hbs_cfg_if.sv ***
// Interface carrying settings from the register file to the sequencer
`timescale 1ns/1ns
`default_nettype none
interface hbs_cfg_if;
    logic signed [15:0] extra_release;
    logic signed [15:0] extra_apply;
    logic [1:0] manual_ctl;
    logic stage_enabled;

    modport regs (
        output extra_release,
        output extra_apply,
        output manual_ctl,
        input stage_enabled
    );
    modport core (
        input extra_release,
        input extra_apply,
        input manual_ctl,
        output stage_enabled
    );
endinterface
`default_nettype wire

// *** logic/hbs_ms_timer.sv ***
// Millisecond timer for brake release and apply delays
`timescale 1ns/1ns
`default_nettype none
module hbs_ms_timer
    import hbs_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = HBS_CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clear_i,
    output logic [16:0] ms_count_o
);

    logic [31:0] cyc;

    // Prescaler restarts with the count so every delay begins on a full ms
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || clear_i) begin
            cyc <= 32'h0000_0000;
        end else if (cyc == CYC_PER_MS - 1) begin
            cyc <= 32'h0000_0000;
        end else begin
            cyc <= cyc + 32'h0000_0001;
        end
    end

    // Saturates instead of wrapping, so a long wait never looks short
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || clear_i) begin
            ms_count_o <= 17'h00000;
        end else if (cyc == CYC_PER_MS - 1 && ms_count_o != 17'h1ffff) begin
            ms_count_o <= ms_count_o + 17'h00001;
        end
    end

endmodule
`default_nettype wire

// *** logic/hbs_param_regs.sv ***
// Parameter registers of the holding brake sequencer
`timescale 1ns/1ns
`default_nettype none
module hbs_param_regs
    import hbs_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    hbs_cfg_if.regs cfg
);

    logic signed [15:0] wsig;
    logic hit_rel;
    logic hit_app;
    logic hit_man;
    logic rel_ok;
    logic app_ok;
    logic man_ok;
    logic wr_ok;

    assign wsig = $signed(reg_wdata_i);
    assign hit_rel = reg_addr_i == HBS_OFS_EXTRA_RELEASE;
    assign hit_app = reg_addr_i == HBS_OFS_EXTRA_APPLY;
    assign hit_man = reg_addr_i == HBS_OFS_MANUAL_CTL;
    // Range and power stage checks
    assign rel_ok = hit_rel && !cfg.stage_enabled
        && wsig >= HBS_EXTRA_MIN && wsig <= HBS_EXTRA_RELEASE_MAX;
    assign app_ok = hit_app && !cfg.stage_enabled
        && wsig >= HBS_EXTRA_MIN && wsig <= HBS_EXTRA_APPLY_MAX;
    // Going from manual apply straight to manual release is refused
    assign man_ok = hit_man && reg_wdata_i <= 16'h0002
        && !(reg_wdata_i[1:0] == HBS_MAN_RELEASE
             && cfg.manual_ctl == HBS_MAN_APPLY);
    assign wr_ok = rel_ok || app_ok || man_ok;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg.extra_release <= HBS_RST_EXTRA_RELEASE;
            cfg.extra_apply <= HBS_RST_EXTRA_APPLY;
        end else if (reg_wr_i) begin
            if (rel_ok) begin
                cfg.extra_release <= wsig;
            end
            if (app_ok) begin
                cfg.extra_apply <= wsig;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg.manual_ctl <= HBS_RST_MANUAL_CTL;
        end else if (reg_wr_i && man_ok) begin
            cfg.manual_ctl <= reg_wdata_i[1:0];
        end
    end

    // Write wins if both strobes come together; a read of a bad address errs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_ack_o <= reg_wr_i || reg_rd_i;
            reg_err_o <= reg_wr_i ? !wr_ok
                : (reg_rd_i && !(hit_rel || hit_app || hit_man));
            if (reg_rd_i && !reg_wr_i) begin
                if (hit_rel) begin
                    reg_rdata_o <= cfg.extra_release;
                end else if (hit_app) begin
                    reg_rdata_o <= cfg.extra_apply;
                end else if (hit_man) begin
                    reg_rdata_o <= {14'h0000, cfg.manual_ctl};
                end else begin
                    reg_rdata_o <= 16'h0000;
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** logic/hbs_brake_seq.sv ***
// Holding brake sequencer: brake, motor current and enable gating
`timescale 1ns/1ns
`default_nettype none
module hbs_brake_seq
    import hbs_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = HBS_CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic power_stage_en_req_i,
    input wire logic jog_cancel_i,
    input wire logic [3:0] op_state_i,
    input wire logic standstill_i,
    input wire logic [15:0] nameplate_release_ms_i,
    input wire logic [15:0] nameplate_apply_ms_i,
    input wire logic brake_release_di_i,
    input wire logic brake_release_di_assigned_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    output logic brake_release_o,
    output logic motor_current_o,
    output logic op_enable_permit_o,
    output logic jog_stopped_o
);

    hbs_cfg_if cfg ();

    hbs_state_t state;
    hbs_state_t next_state;
    logic [16:0] ms_count;
    logic [16:0] total_release;
    logic [16:0] total_apply;
    logic jog_block;
    logic eff_req;
    logic manual_apply_active;
    logic manual_release_ok;
    logic di_meta;
    logic di_sync;
    logic next_release;

    ////////////////////////////////////////////////////////////////////////
    // Register file and timer

    hbs_param_regs u_regs (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_ack_o(reg_ack_o),
        .reg_err_o(reg_err_o),
        .cfg(cfg.regs)
    );

    hbs_ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(state != next_state),
        .ms_count_o(ms_count)
    );

    assign cfg.stage_enabled = state != HBS_OFF;

    ////////////////////////////////////////////////////////////////////////
    // Jog cancel and enable request

    // Cancel holds the stage off until the request itself is withdrawn
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            jog_block <= 1'b0;
        end else if (jog_cancel_i) begin
            jog_block <= 1'b1;
        end else if (!power_stage_en_req_i) begin
            jog_block <= 1'b0;
        end
    end

    assign eff_req = power_stage_en_req_i && !jog_block && !jog_cancel_i;
    assign jog_stopped_o = jog_block;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        next_state = state;
        case (state)
            HBS_OFF: begin
                if (eff_req) begin
                    next_state = HBS_RELEASING;
                end
            end
            HBS_RELEASING: begin
                if (!eff_req) begin
                    next_state = HBS_APPLYING;
                end else if (ms_count >= total_release) begin
                    next_state = HBS_ENABLED;
                end
            end
            HBS_ENABLED: begin
                if (!eff_req) begin
                    next_state = HBS_APPLYING;
                end
            end
            HBS_APPLYING: begin
                // A new request waits until the apply delay has run out
                if (ms_count >= total_apply) begin
                    next_state = HBS_OFF;
                end
            end
            default: begin
                next_state = HBS_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= HBS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Totals frozen at the enable edge; later writes wait for the next one
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            total_release <= 17'h00000;
            total_apply <= 17'h00000;
        end else if (state == HBS_OFF && next_state == HBS_RELEASING) begin
            total_release <= {1'b0, nameplate_release_ms_i}
                + {1'b0, cfg.extra_release};
            total_apply <= {1'b0, nameplate_apply_ms_i}
                + {1'b0, cfg.extra_apply};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Manual control and signal input

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            manual_apply_active <= 1'b0;
        end else if (cfg.manual_ctl != HBS_MAN_APPLY) begin
            manual_apply_active <= 1'b0;
        end else if (standstill_i) begin
            manual_apply_active <= 1'b1;
        end
    end

    assign manual_release_ok = cfg.manual_ctl == HBS_MAN_RELEASE
        && (op_state_i == HBS_OPST_SWITCH_ON_DISABLED
            || op_state_i == HBS_OPST_READY_TO_SWITCH_ON
            || op_state_i == HBS_OPST_FAULT);

    // The pin is asynchronous to the drive clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            di_meta <= 1'b0;
            di_sync <= 1'b0;
        end else begin
            di_meta <= brake_release_di_i;
            di_sync <= di_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        next_release = 1'b0;
        if (state == HBS_RELEASING || state == HBS_ENABLED) begin
            next_release = 1'b1;
        end
        if (manual_release_ok) begin
            next_release = 1'b1;
        end
        if (di_sync && brake_release_di_assigned_i) begin
            next_release = 1'b1;
        end
        if (manual_apply_active) begin
            next_release = 1'b0;
        end
    end

    // Sequencer brake release follows current by a cycle; manual and input releases need no current
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            brake_release_o <= 1'b0;
        end else begin
            brake_release_o <= next_release;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            motor_current_o <= 1'b0;
        end else begin
            motor_current_o <= next_state != HBS_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            op_enable_permit_o <= 1'b0;
        end else begin
            op_enable_permit_o <= next_state == HBS_ENABLED;
        end
    end

endmodule
`default_nettype wire

// *** testbench/hbs_motor_model.sv ***
// Far-side model: motor shaft driven by the power stage current
`timescale 1ns/1ns
`default_nettype none
module hbs_motor_model (
    input wire logic clk_i,
    input wire logic motor_current_i,
    input wire logic move_cmd_i,
    output logic standstill_o
);
    // Torque against an applied brake still turns the shaft, only with wear
    always_ff @(posedge clk_i) begin
        standstill_o <= !(move_cmd_i && motor_current_i);
    end
endmodule
`default_nettype wire

// *** testbench/hbs_chk_sva.sv ***
// Port checker of the holding brake sequencer
`timescale 1ns/1ns
`default_nettype none
module hbs_chk
    import hbs_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic power_stage_en_req_i,
    input wire logic jog_cancel_i,
    input wire logic [3:0] op_state_i,
    input wire logic brake_release_di_assigned_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_err_o,
    input wire logic brake_release_o,
    input wire logic motor_current_o,
    input wire logic op_enable_permit_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////
    AST_RST_OUT: assert property (
        $fell(sys_rst_i) |-> !(brake_release_o | motor_current_o
        | op_enable_permit_o)) else $error("Outputs set after reset");
    // Permit may only follow an edge with the request held and no cancel
    AST_PERMIT_CUR: assert property (
        op_enable_permit_o |-> motor_current_o
        && $past(power_stage_en_req_i) && !$past(jog_cancel_i))
        else $error("Permit without current or request");
    AST_DROP_APPLY: assert property (
        $fell(power_stage_en_req_i) && motor_current_o
        |-> ##2 !brake_release_o && !op_enable_permit_o)
        else $error("Brake not applied on disable");
    // Brake falls while current flows: current must then stay on for 8 cycles
    AST_CUR_HOLD: assert property (
        $fell(brake_release_o) && motor_current_o |-> motor_current_o[*8])
        else $error("Current cut too early");
    AST_JOG_STOP: assert property (
        jog_cancel_i && motor_current_o
        |-> ##2 !brake_release_o && !op_enable_permit_o)
        else $error("Jog cancel left brake released");
    AST_REL_REFUSE: assert property (
        reg_wr_i && reg_addr_i == HBS_OFS_EXTRA_RELEASE
        && (motor_current_o || reg_wdata_i > 16'h0190) |=> reg_err_o)
        else $error("Bad release delay write taken");
    AST_APP_REFUSE: assert property (
        reg_wr_i && reg_addr_i == HBS_OFS_EXTRA_APPLY
        && (motor_current_o || reg_wdata_i > 16'h03e8) |=> reg_err_o)
        else $error("Bad apply delay write taken");
    AST_MAN_CODE: assert property (
        reg_wr_i && reg_addr_i == HBS_OFS_MANUAL_CTL
        && reg_wdata_i > 16'h0002 |=> reg_err_o)
        else $error("Bad manual code taken");
    AST_MAN_STATE: assert property (
        brake_release_o && !motor_current_o
        && !$past(brake_release_di_assigned_i)
        |-> $past(op_state_i) inside {4'h3, 4'h4, 4'h9})
        else $error("Manual release in wrong state");
    cover property ($rose(op_enable_permit_o));
    cover property ($fell(motor_current_o));
    cover property (jog_cancel_i && motor_current_o);
endmodule
bind hbs_brake_seq hbs_chk i_chk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .power_stage_en_req_i(power_stage_en_req_i),
    .jog_cancel_i(jog_cancel_i),
    .op_state_i(op_state_i),
    .brake_release_di_assigned_i(brake_release_di_assigned_i),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_err_o(reg_err_o),
    .brake_release_o(brake_release_o),
    .motor_current_o(motor_current_o),
    .op_enable_permit_o(op_enable_permit_o)
);
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench of the holding brake sequencer
`timescale 1ns/1ns
`default_nettype none
module tb
    import hbs_pkg::*;
;
    typedef struct packed {
        logic w;
        logic [15:0] a;
        logic [15:0] d;
        logic e;
        logic [15:0] r;
    } hbs_row_t;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic power_stage_en_req_i = 1'b0;
    logic jog_cancel_i = 1'b0;
    logic [3:0] op_state_i = 4'h5;
    logic [15:0] nameplate_release_ms_i = 16'h0002;
    logic [15:0] nameplate_apply_ms_i = 16'h0001;
    logic brake_release_di_i = 1'b0;
    logic brake_release_di_assigned_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic move_cmd = 1'b0;
    logic standstill_i, reg_ack_o, reg_err_o, brake_release_o;
    logic motor_current_o, op_enable_permit_o, jog_stopped_o;
    logic [15:0] reg_rdata_o;
    logic [3:0] st [4] = '{4'h3, 4'h4, 4'h9, 4'h5};
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    // Reads of known addresses expect err 0; refused writes expect err 1 and no change
    hbs_row_t rw [14] = '{
        '{0, 16'h050e, 0, 0, 0}, '{0, 16'h0510, 0, 0, 0},
        '{1, 16'h050e, 16'h0190, 0, 0}, '{0, 16'h050e, 0, 0, 16'h0190},
        '{1, 16'h050e, 16'h0191, 1, 0}, '{1, 16'h050e, 16'hffff, 1, 0},
        '{0, 16'h050e, 0, 0, 16'h0190}, '{1, 16'h0510, 16'h03e8, 0, 0},
        '{1, 16'h0510, 16'h03e9, 1, 0}, '{0, 16'h0510, 0, 0, 16'h03e8},
        '{1, 16'h0814, 16'h0003, 1, 0}, '{0, 16'h0814, 0, 0, 0},
        '{0, 16'h1234, 0, 1, 0}, '{1, 16'h1234, 16'h0001, 1, 0}};
    hbs_brake_seq #(
        .CYC_PER_MS(10)
    ) i_dut (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .power_stage_en_req_i(power_stage_en_req_i),
        .jog_cancel_i(jog_cancel_i),
        .op_state_i(op_state_i),
        .standstill_i(standstill_i),
        .nameplate_release_ms_i(nameplate_release_ms_i),
        .nameplate_apply_ms_i(nameplate_apply_ms_i),
        .brake_release_di_i(brake_release_di_i),
        .brake_release_di_assigned_i(brake_release_di_assigned_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_ack_o(reg_ack_o),
        .reg_err_o(reg_err_o),
        .brake_release_o(brake_release_o),
        .motor_current_o(motor_current_o),
        .op_enable_permit_o(op_enable_permit_o),
        .jog_stopped_o(jog_stopped_o)
    );
    hbs_motor_model i_mdl (.clk_i(clk_i), .motor_current_i(motor_current_o),
        .move_cmd_i(move_cmd), .standstill_o(standstill_i));
    always #10 clk_i = ~clk_i;
    ////////////////////////////////////////
    task automatic end_sim();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic bus(input hbs_row_t x);
        @(negedge clk_i);
        reg_wr_i = x.w;
        reg_rd_i = !x.w;
        reg_addr_i = x.a;
        reg_wdata_i = x.d;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        chk({14'h0, reg_ack_o, reg_err_o}, {14'h0, 1'b1, x.e});
        if (!x.w) chk(reg_rdata_o, x.r);
    endtask
    task automatic wr(input logic [15:0] a, d, input logic e);
        hbs_row_t x;
        x = '{1'b1, a, d, e, 16'h0000};
        bus(x);
    endtask
    // One enable and disable pass; windows allow the registered latency
    task automatic cyc(input int rel, app);
        int n;
        n = 0;
        power_stage_en_req_i = 1'b1;
        wt(2);
        chk(16'({motor_current_o, brake_release_o}), 16'h3);
        while (op_enable_permit_o !== 1'b1 && n < 2000) begin
            wt(1);
            n++;
        end
        chk(16'(n >= 10*rel-2 && n <= 10*rel+3), 16'h1);
        wr(HBS_OFS_EXTRA_RELEASE, 16'h0000, 1);
        n = 0;
        power_stage_en_req_i = 1'b0;
        wt(2);
        chk(16'({brake_release_o, op_enable_permit_o}), 16'h0);
        while (motor_current_o !== 1'b0 && n < 2000) begin
            wt(1);
            n++;
        end
        chk(16'(n >= 10*app-2 && n <= 10*app+3), 16'h1);
    endtask
    ////////////////////////////////////////
    initial begin
        wt(5);
        sys_rst_i = 1'b0;
        foreach (rw[i]) bus(rw[i]);
        wr(HBS_OFS_EXTRA_RELEASE, 16'h0003, 0);
        wr(HBS_OFS_EXTRA_APPLY, 16'h0002, 0);
        cyc(5, 3);
        bus('{0, HBS_OFS_EXTRA_RELEASE, 0, 0, 16'h0003});
        wr(HBS_OFS_EXTRA_RELEASE, 16'h0000, 0);
        wr(HBS_OFS_EXTRA_APPLY, 16'h0000, 0);
        cyc(2, 1);
        foreach (st[i]) begin
            op_state_i = st[i];
            wr(HBS_OFS_MANUAL_CTL, 16'h0001, 0);
            wt(1);
            chk(16'(brake_release_o), 16'(i < 3));
            wr(HBS_OFS_MANUAL_CTL, 16'h0000, 0);
        end
        move_cmd = 1'b1;
        power_stage_en_req_i = 1'b1;
        wr(HBS_OFS_MANUAL_CTL, 16'h0002, 0);
        wt(3);
        chk(16'(brake_release_o), 16'h1);
        move_cmd = 1'b0;
        wt(4);
        chk(16'({brake_release_o, motor_current_o}), 16'h1);
        power_stage_en_req_i = 1'b0;
        wt(40);
        power_stage_en_req_i = 1'b1;
        wt(5);
        chk(16'({brake_release_o, motor_current_o}), 16'h1);
        power_stage_en_req_i = 1'b0;
        wt(40);
        op_state_i = 4'h3;
        wr(HBS_OFS_MANUAL_CTL, 16'h0001, 1);
        wt(2);
        chk(16'(brake_release_o), 16'h0);
        wr(HBS_OFS_MANUAL_CTL, 16'h0000, 0);
        wr(HBS_OFS_MANUAL_CTL, 16'h0001, 0);
        wt(1);
        chk(16'(brake_release_o), 16'h1);
        wr(HBS_OFS_MANUAL_CTL, 16'h0000, 0);
        op_state_i = 4'h4;
        brake_release_di_i = 1'b1;
        wt(5);
        chk(16'(brake_release_o), 16'h0);
        brake_release_di_assigned_i = 1'b1;
        wt(4);
        chk(16'(brake_release_o), 16'h1);
        brake_release_di_i = 1'b0;
        wt(4);
        chk(16'(brake_release_o), 16'h0);
        brake_release_di_assigned_i = 1'b0;
        op_state_i = 4'h5;
        power_stage_en_req_i = 1'b1;
        wt(30);
        jog_cancel_i = 1'b1;
        wt(1);
        jog_cancel_i = 1'b0;
        wt(1);
        chk(16'({brake_release_o, op_enable_permit_o, jog_stopped_o,
            motor_current_o}), 16'h3);
        power_stage_en_req_i = 1'b0;
        wt(20);
        chk(16'({motor_current_o, jog_stopped_o}), 16'h0);
        // Leave non-reset values behind so the mid-run reset must clear them
        wr(HBS_OFS_EXTRA_RELEASE, 16'h0005, 0);
        wr(HBS_OFS_MANUAL_CTL, 16'h0002, 0);
        power_stage_en_req_i = 1'b1;
        wt(30);
        sys_rst_i = 1'b1;
        wt(1);
        sys_rst_i = 1'b0;
        power_stage_en_req_i = 1'b0;
        chk(16'({brake_release_o, motor_current_o, op_enable_permit_o,
            jog_stopped_o}), 16'h0);
        bus('{0, HBS_OFS_EXTRA_RELEASE, 0, 0, 16'h0000});
        bus('{0, HBS_OFS_MANUAL_CTL, 0, 0, 16'h0000});
        end_sim();
    end
    // Whole run takes under a thousand cycles; the limit is generous
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
endmodule
`default_nettype wire
